/* verilog/fhrb_device.sv */
// Device end: holding register bank with output gating
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
// Notes on behaviour
// - Only cyclic process data exchange is used
// - Byte offset equals twice the word index
// - Words 0,1 unused; command at word 2
// - Minimum zero; master stays within maximum
// - Command bit 1 selects local set point
// - Command bit 2 requests output enable
// - Command bit 4 selects local current limit
// - Other command bits have no effect
// - Set point is percent times 10.23
// - Output scale is percent times 2.55
// - Read-write access: bit 1 alone picks source
// - Read-write with input: enable needs both
// - Zero command selects analog inputs; without read-write access, din_sp_cfg_i lets din_sp_local_i pick set point
module fhrb_device #(
	parameter int SP_W  = 10, // Set point output width
	parameter int OSC_W = 8   // Output scale width
) (
	input  wire logic           ref_clk_i,
	input  wire logic           rst_i,
	input  wire logic           clk_en_i,
	fhrb_link_if.device         link,
	input  wire logic           port_rw_access_i,
	input  wire logic           din_sp_local_i,
	input  wire logic           din_sp_cfg_i,
	input  wire logic           din_enable_i,
	input  wire logic           din_enable_cfg_i,
	output logic                sp_local_o,
	output logic                il_local_o,
	output logic                out_enable_o,
	output logic [SP_W-1:0]     set_point_o,
	output logic [OSC_W-1:0]    out_scale_o
);
	import fhrb_pkg::*;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Narrower outputs would drop bits of a legal stored value
	if (SP_W < $countones(SETPOINT_MAX) || SP_W > WORD_W) begin : g_sp_w_chk
		$error("set point width out of range");
	end
	if (OSC_W < $countones(OUTSCALE_MAX) || OSC_W > WORD_W) begin : g_osc_w_chk
		$error("output scale width out of range");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Stored words keep their defined width only; the master bounds the value
	// Masking instead of refusing keeps the bank free of error state
	function automatic logic [15:0] clip_word(
		input logic [15:0] val,
		input logic [15:0] lim
	);
		return val & lim;
	endfunction : clip_word

	// Odd offsets and unused words read back as zero
	function automatic logic [15:0] read_word(
		input logic [3:0]  ofs,
		input logic [15:0] cmd,
		input logic [15:0] sp,
		input logic [15:0] osc
	);
		logic [15:0] res;
		res = WORD_RESET;
		if (!ofs[0]) begin
			unique case (ofs[3:1])
				IDX_COMMAND:  res = cmd;
				IDX_SETPOINT: res = sp;
				IDX_OUTSCALE: res = osc;
				default:      res = WORD_RESET;
			endcase
		end
		return res;
	endfunction : read_word

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	logic [15:0] cmd_r;
	logic [15:0] cmd_nxt;
	logic [15:0] sp_r;
	logic [15:0] sp_nxt;
	logic [15:0] osc_r;
	logic [15:0] osc_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic [2:0]  idx;
	logic        ofs_odd;

	assign idx     = link.byte_ofs[3:1];
	assign ofs_odd = link.byte_ofs[0];

	always_comb begin
		cmd_nxt    = cmd_r;
		sp_nxt     = sp_r;
		osc_nxt    = osc_r;
		rdata_nxt  = rdata_r;
		rvalid_nxt = 1'b0;
		// Odd byte offsets do not address a word and are ignored
		if (link.wr && !ofs_odd) begin
			unique case (idx)
				IDX_COMMAND:  cmd_nxt = link.wdata;
				IDX_SETPOINT: sp_nxt  = clip_word(link.wdata, SETPOINT_MAX);
				IDX_OUTSCALE: osc_nxt = clip_word(link.wdata, OUTSCALE_MAX);
				default:      ;
			endcase
		end
		// A read answers once, the cycle after it is taken
		// Writes and reads may share a cycle; the read sees the old word
		if (link.rd) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = read_word(link.byte_ofs, cmd_r, sp_r, osc_r);
		end
	end

	// Clock enable low freezes every word and the read answer
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_r    <= WORD_RESET;
			sp_r     <= WORD_RESET;
			osc_r    <= WORD_RESET;
			rdata_r  <= WORD_RESET;
			rvalid_r <= 1'b0;
		end else if (clk_en_i) begin
			cmd_r    <= cmd_nxt;
			sp_r     <= sp_nxt;
			osc_r    <= osc_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ------------------------------------------------------------
	// Link answer
	// ------------------------------------------------------------
	assign link.rdata  = rdata_r;
	assign link.rvalid = rvalid_r;

	// ------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------
	// Only bits 1, 2 and 4 are ever looked at
	logic             sp_loc_nxt;
	logic             sp_loc_r;
	logic             il_loc_nxt;
	logic             il_loc_r;
	logic             en_nxt;
	logic             en_r;
	logic [SP_W-1:0]  spo_nxt;
	logic [SP_W-1:0]  spo_r;
	logic [OSC_W-1:0] oso_nxt;
	logic [OSC_W-1:0] oso_r;

	always_comb begin
		// Zero command means bits 1 and 4 are 0: analog source, unless din_sp_cfg_i picks din_sp_local_i (no read-write access)
		if (port_rw_access_i) begin
			sp_loc_nxt = cmd_r[CMD_SP_LOCAL];
		end else begin
			sp_loc_nxt = din_sp_cfg_i ? din_sp_local_i : cmd_r[CMD_SP_LOCAL];
		end
		il_loc_nxt = cmd_r[CMD_IL_LOCAL];
		// The digital input only gates the request; it never enables alone
		if (port_rw_access_i && din_enable_cfg_i) begin
			en_nxt = cmd_r[CMD_OUT_EN] && din_enable_i;
		end else begin
			en_nxt = cmd_r[CMD_OUT_EN];
		end
		// Outputs copy the clipped words one cycle later
		spo_nxt = SP_W'(sp_r);
		oso_nxt = OSC_W'(osc_r);
	end

	// Outputs reset low so the power stage stays off until commanded
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sp_loc_r <= 1'b0;
			il_loc_r <= 1'b0;
			en_r     <= 1'b0;
			spo_r    <= '0;
			oso_r    <= '0;
		end else if (clk_en_i) begin
			sp_loc_r <= sp_loc_nxt;
			il_loc_r <= il_loc_nxt;
			en_r     <= en_nxt;
			spo_r    <= spo_nxt;
			oso_r    <= oso_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every output comes straight from a flip-flop
	assign sp_local_o   = sp_loc_r;
	assign il_local_o   = il_loc_r;
	assign out_enable_o = en_r;
	assign set_point_o  = spo_r;
	assign out_scale_o  = oso_r;
endmodule : fhrb_device

/* verilog/fhrb_pkg.sv */
// Shared constants for the fieldbus holding register bank
package fhrb_pkg;
	// ------------------------------------------------------------
	// Word map
	// ------------------------------------------------------------
	localparam int          WORD_W        = 16;
	localparam int          IDX_W         = 3;
	localparam logic [2:0]  IDX_UNUSED0   = 3'h0;
	localparam logic [2:0]  IDX_UNUSED1   = 3'h1;
	localparam logic [2:0]  IDX_COMMAND   = 3'h2;
	localparam logic [2:0]  IDX_SETPOINT  = 3'h3;
	localparam logic [2:0]  IDX_OUTSCALE  = 3'h4;
	localparam int          NUM_WORDS     = 5;
	// ------------------------------------------------------------
	// Command word fields
	// ------------------------------------------------------------
	localparam int          CMD_SP_LOCAL  = 1;
	localparam int          CMD_OUT_EN    = 2;
	localparam int          CMD_IL_LOCAL  = 4;
	// ------------------------------------------------------------
	// Limits and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] SETPOINT_MAX  = 16'h03FF;
	localparam logic [15:0] OUTSCALE_MAX  = 16'h00FF;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	// Host register map (local port of the master end)
	localparam logic [3:0]  HREG_CTRL     = 4'h0;
	localparam logic [3:0]  HREG_STATUS   = 4'h1;
	localparam logic [3:0]  HREG_RDATA    = 4'h2;
	localparam logic [3:0]  HREG_WDATA    = 4'h3;
	localparam logic [3:0]  HREG_INDEX    = 4'h4;

	// Byte offset on the cyclic image is twice the word index
	function automatic logic [3:0] fhrb_byte_offset(input logic [2:0] idx);
		fhrb_byte_offset = {idx, 1'b0};
	endfunction : fhrb_byte_offset

	// Highest legal value of a writable word
	function automatic logic [15:0] fhrb_word_max(input logic [2:0] idx);
		unique case (idx)
			IDX_SETPOINT: fhrb_word_max = SETPOINT_MAX;
			IDX_OUTSCALE: fhrb_word_max = OUTSCALE_MAX;
			default:      fhrb_word_max = 16'hFFFF;
		endcase
	endfunction : fhrb_word_max
endpackage : fhrb_pkg

/* verilog/fhrb_link_if.sv */
// Cyclic process-data link between fieldbus master and device
`timescale 1ns/1ns
interface fhrb_link_if;
	logic        wr;       // Cyclic output write of one word
	logic        rd;       // Read-back request
	logic [3:0]  byte_ofs; // Byte offset into the output image
	logic [15:0] wdata;
	logic [15:0] rdata;    // Valid the cycle after rd
	logic        rvalid;
	modport device (input wr, input rd, input byte_ofs, input wdata, output rdata, output rvalid);
	modport master (output wr, output rd, output byte_ofs, output wdata, input rdata, input rvalid);
endinterface : fhrb_link_if

/* verilog/fhrb_master.sv */
// Master end: drives cyclic word writes and read-backs from a local port
`timescale 1ns/1ns
module fhrb_master (
	input  wire logic           ref_clk_i,
	input  wire logic           rst_i,
	input  wire logic           clk_en_i,
	fhrb_link_if.master         link,
	input  wire logic [3:0]     addr_i,
	input  wire logic [15:0]    wdata_i,
	input  wire logic           wr_i,
	input  wire logic           rd_i,
	output logic [15:0]         rdata_o
);
	import fhrb_pkg::*;

	// ------------------------------------------------------------
	// Local registers
	// ------------------------------------------------------------
	// CTRL: bit0 write go, bit1 read go (self-clearing)
	// STATUS: bit0 busy, bit1 last value refused as over range
	logic [2:0]  index_r, index_nxt;
	logic [15:0] wd_r, wd_nxt, rb_r, rb_nxt, rdo_r, rdo_nxt;
	logic        lwr_r, lwr_nxt, lrd_r, lrd_nxt, busy_r, busy_nxt, ovr_r, ovr_nxt;

	always_comb begin
		index_nxt = index_r;
		wd_nxt    = wd_r;
		rb_nxt    = rb_r;
		lwr_nxt   = 1'b0;
		lrd_nxt   = 1'b0;
		busy_nxt  = busy_r;
		ovr_nxt   = ovr_r;
		rdo_nxt   = rdo_r;
		if (link.rvalid) begin
			rb_nxt   = link.rdata;
			busy_nxt = 1'b0;
		end
		if (wr_i) begin
			unique case (addr_i)
				HREG_WDATA: wd_nxt = wdata_i;
				HREG_INDEX: index_nxt = wdata_i[2:0];
				HREG_CTRL: begin
					if (wdata_i[0]) begin
						// Never send a value above the word maximum
						if (wd_r > fhrb_word_max(index_r)) begin
							ovr_nxt = 1'b1;
						end else begin
							lwr_nxt = 1'b1;
							ovr_nxt = 1'b0;
						end
					end else if (wdata_i[1]) begin
						lrd_nxt  = 1'b1;
						busy_nxt = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				HREG_STATUS: rdo_nxt = {14'h0000, ovr_r, busy_r};
				HREG_RDATA:  rdo_nxt = rb_r;
				HREG_WDATA:  rdo_nxt = wd_r;
				HREG_INDEX:  rdo_nxt = {13'h0000, index_r};
				default:     rdo_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			index_r <= IDX_COMMAND;
			wd_r    <= WORD_RESET;
			rb_r    <= WORD_RESET;
			rdo_r   <= WORD_RESET;
			lwr_r   <= 1'b0;
			lrd_r   <= 1'b0;
			busy_r  <= 1'b0;
			ovr_r   <= 1'b0;
		end else if (clk_en_i) begin
			index_r <= index_nxt;
			wd_r    <= wd_nxt;
			rb_r    <= rb_nxt;
			rdo_r   <= rdo_nxt;
			lwr_r   <= lwr_nxt;
			lrd_r   <= lrd_nxt;
			busy_r  <= busy_nxt;
			ovr_r   <= ovr_nxt;
		end
	end

	assign link.wr       = lwr_r;
	assign link.rd       = lrd_r;
	assign link.byte_ofs = fhrb_byte_offset(index_r);
	assign link.wdata    = wd_r;
	assign rdata_o       = rdo_r;
endmodule : fhrb_master

/* bench/fhrb_link_assertions.sv */
// Concurrent checks on the cyclic link and the device outputs
`timescale 1ns/1ns
module fhrb_link_assertions (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        clk_en_i,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [3:0]  byte_ofs,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        rvalid,
	input wire logic        port_rw_access_i,
	input wire logic        din_enable_i,
	input wire logic        din_enable_cfg_i,
	input wire logic        sp_local_o,
	input wire logic        il_local_o,
	input wire logic        out_enable_o,
	input wire logic [9:0]  set_point_o
);
	// ----------------------------------------
	// Delayed copies
	// ----------------------------------------
	// Outputs trail a command write by two edges, so the word is kept that long
	logic [15:0] wd1_r;
	logic [15:0] wd2_r;
	logic        den_r;
	always_ff @(posedge ref_clk_i) begin
		wd1_r <= wdata;
		wd2_r <= wd1_r;
		den_r <= din_enable_i;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	read_answer_a: assert property (rd && clk_en_i |=> rvalid) else $error("no read answer");
	rvalid_cause_a: assert property (rvalid && $past(clk_en_i) |-> $past(rd)) else $error("stray rvalid");
	unused_read_a: assert property (rd && clk_en_i && byte_ofs < 4'h4 |=> rvalid && rdata == 16'h0000)
		else $error("unused word not zero");
	sp_source_a: assert property (wr && clk_en_i && byte_ofs == 4'h4 ##1 clk_en_i && port_rw_access_i
		|=> sp_local_o == wd2_r[1]) else $error("set point source wrong");
	il_source_a: assert property (wr && clk_en_i && byte_ofs == 4'h4 ##1 clk_en_i
		|=> il_local_o == wd2_r[4]) else $error("current limit source wrong");
	out_gate_a: assert property (wr && clk_en_i && byte_ofs == 4'h4 ##1 clk_en_i && port_rw_access_i && din_enable_cfg_i
		|=> out_enable_o == (wd2_r[2] && den_r)) else $error("gated enable wrong");
	out_plain_a: assert property (wr && clk_en_i && byte_ofs == 4'h4 ##1 clk_en_i && !din_enable_cfg_i
		|=> out_enable_o == wd2_r[2]) else $error("enable wrong");
	set_point_a: assert property (wr && clk_en_i && byte_ofs == 4'h6 ##1 clk_en_i
		|=> set_point_o == 10'($past(wdata, 2))) else $error("set point wrong");
endmodule : fhrb_link_assertions

/* bench/fhrb_tb_top.sv */
// Self-checking bench joining master and device ends
`timescale 1ns/1ns
module fhrb_tb_top;
	import fhrb_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic [15:0] rdata_o;
	logic port_rw_access_i = 1'b1;
	logic din_sp_local_i = 1'b0;
	logic din_sp_cfg_i = 1'b0;
	logic din_enable_i = 1'b0;
	logic din_enable_cfg_i = 1'b0;
	logic sp_local_o, il_local_o, out_enable_o;
	logic [9:0] set_point_o;
	logic [7:0] out_scale_o;
	logic [15:0] d;
	logic [15:0] cmds [5] = '{16'h0002, 16'h0004, 16'h0010, 16'hFFE9, 16'h0016};
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	wire [15:0] ctl_w = {13'h0000, il_local_o, out_enable_o, sp_local_o};
	fhrb_link_if link ();
	fhrb_device u_fhrb_device (.ref_clk_i, .rst_i, .clk_en_i, .link(link), .port_rw_access_i, .din_sp_local_i,
		.din_sp_cfg_i, .din_enable_i, .din_enable_cfg_i, .sp_local_o, .il_local_o, .out_enable_o, .set_point_o, .out_scale_o);
	fhrb_master u_fhrb_master (.ref_clk_i, .rst_i, .clk_en_i, .link(link), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
	fhrb_link_assertions u_fhrb_link_assertions (.ref_clk_i, .rst_i, .clk_en_i, .wr(link.wr), .rd(link.rd),
		.byte_ofs(link.byte_ofs), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid), .port_rw_access_i,
		.din_enable_i, .din_enable_cfg_i, .sp_local_o, .il_local_o, .out_enable_o, .set_point_o);
	// ----------------------------------------
	// Clock, timeout and access tasks
	// ----------------------------------------
	always #50 ref_clk_i = ~ref_clk_i;
	// The whole run needs well under 2000 cycles
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic hw(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : hw
	task automatic hr(input logic [3:0] a, output logic [15:0] v);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata_o;
	endtask : hr
	task automatic settle();
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask : settle
	task automatic put(input logic [2:0] i, input logic [15:0] v);
		hw(HREG_WDATA, v);
		hw(HREG_INDEX, {13'h0000, i});
		hw(HREG_CTRL, 16'h0001);
		settle();
	endtask : put
	task automatic get(input logic [2:0] i, output logic [15:0] v);
		hw(HREG_INDEX, {13'h0000, i});
		hw(HREG_CTRL, 16'h0002);
		repeat (2) @(posedge ref_clk_i);
		hr(HREG_RDATA, v);
	endtask : get
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(ctl_w, 16'h0000);
		get(IDX_COMMAND, d);
		chk(d, 16'h0000);
		$display("test reset done");
		@(posedge ref_clk_i);
		din_sp_cfg_i <= 1'b1;
		din_sp_local_i <= 1'b1;
		foreach (cmds[k]) begin
			put(IDX_COMMAND, cmds[k]);
			chk(ctl_w, {13'h0000, cmds[k][4], cmds[k][2], cmds[k][1]});
			get(IDX_COMMAND, d);
			chk(d, cmds[k]);
		end
		$display("test command done");
		@(posedge ref_clk_i);
		din_enable_cfg_i <= 1'b1;
		put(IDX_COMMAND, 16'h0004);
		chk(ctl_w, 16'h0000);
		@(posedge ref_clk_i);
		din_enable_i <= 1'b1;
		settle();
		chk(ctl_w, 16'h0002);
		@(posedge ref_clk_i);
		port_rw_access_i <= 1'b0;
		din_enable_i <= 1'b0;
		settle();
		chk(ctl_w, 16'h0003);
		@(posedge ref_clk_i);
		port_rw_access_i <= 1'b1;
		$display("test gating done");
		put(IDX_SETPOINT, SETPOINT_MAX);
		put(IDX_OUTSCALE, OUTSCALE_MAX);
		chk({6'h00, set_point_o}, SETPOINT_MAX);
		chk({8'h00, out_scale_o}, OUTSCALE_MAX);
		put(IDX_SETPOINT, 16'h0400);
		hr(HREG_STATUS, d);
		chk(d & 16'h0002, 16'h0002);
		get(IDX_SETPOINT, d);
		chk(d, SETPOINT_MAX);
		put(IDX_OUTSCALE, 16'h0100);
		get(IDX_OUTSCALE, d);
		chk(d, OUTSCALE_MAX);
		$display("test limits done");
		put(IDX_UNUSED0, 16'h1234);
		get(IDX_UNUSED0, d);
		chk(d, 16'h0000);
		get(IDX_UNUSED1, d);
		chk(d, 16'h0000);
		hw(4'hF, 16'h0000);
		get(IDX_COMMAND, d);
		chk(d, 16'h0004);
		$display("test unused done");
		@(posedge ref_clk_i);
		clk_en_i <= 1'b0;
		hw(HREG_WDATA, 16'h0010);
		hw(HREG_CTRL, 16'h0001);
		clk_en_i <= 1'b1;
		get(IDX_COMMAND, d);
		chk(d, 16'h0004);
		chk(ctl_w, 16'h0000);
		$display("test freeze done");
		final_report();
	end
endmodule : fhrb_tb_top
